/* File: rtl/pse_stat_events.v */
// statistics event sources and one selectable statistics counter
// How it works
// - accumulate issue-to-last-completion time, chosen client
// - count chosen client read requests
// - accumulate issue-to-first-completion time
// - count chosen client requests for round trip
// - count requests reaching completion timeout
// - time request start to completions end
// - count end-of-completion times above threshold
// - time request start to first completion
// - count first-completion times above threshold
// - add transmitted dwords, one or two
// - add received dwords, one or two
// - count cycles sending any DLLP
// - count flow-control and Ack DLLPs sent
// - count cycles receiving any DLLP
// - count flow-control, Ack, Nack received
`timescale 1ns/10ps
`include "pse_defs.vh"
module pse_stat_events (
	input wire i_clk_sys,
	input wire i_reset,
	input wire [`PSE_CODE_W-1:0] i_event_sel,
	input wire [`PSE_CLIENT_W-1:0] i_client_sel,
	input wire [`PSE_THR_W-1:0] i_latency_threshold_setting,
	input wire i_counter_clear,
	input wire i_rd_req,
	input wire [`PSE_CLIENT_W-1:0] i_rd_req_client,
	input wire i_first_cpl,
	input wire i_last_cpl,
	input wire i_req_timeout,
	input wire [1:0] i_tx_dwords,
	input wire [1:0] i_rx_dwords,
	input wire i_tx_dllp,
	input wire i_tx_fc_dllp,
	input wire i_tx_ack_dllp,
	input wire i_rx_dllp,
	input wire i_rx_fc_dllp,
	input wire i_rx_ack_dllp,
	input wire i_rx_nak_dllp,
	output wire [`PSE_CNT_W-1:0] o_count,
	output wire [`PSE_CNT_W-1:0] o_time_acc,
	output wire o_full_busy,
	output wire o_rtt_busy
);
	reg [`PSE_CNT_W-1:0] count_q;
	reg [`PSE_CNT_W-1:0] count_d;
	reg [`PSE_CNT_W-1:0] time_q;
	reg [`PSE_CNT_W-1:0] time_d;
	reg [`PSE_CODE_W-1:0] sel_q;
	reg rtt_seen_q;
	wire my_req;
	wire full_busy;
	wire full_tick;
	wire full_done;
	wire rtt_busy;
	wire rtt_tick;
	wire rtt_done;
	wire full_above;
	wire rtt_above;
	wire [`PSE_CNT_W-1:0] full_elapsed;
	wire [`PSE_CNT_W-1:0] rtt_elapsed;
	wire rtt_stop;

	function [`PSE_CNT_W-1:0] widen;
		input [1:0] v;
		begin
			widen = {30'h00000000, v};
		end
	endfunction

	function [`PSE_CNT_W-1:0] flag;
		input f;
		begin
			flag = {31'h00000000, f};
		end
	endfunction

	assign o_count = count_q;
	assign o_time_acc = time_q;
	assign o_full_busy = full_busy;
	assign o_rtt_busy = rtt_busy;

	// one request tracked at a time; others of the client pass untimed
	assign my_req = i_rd_req & (i_rd_req_client == i_client_sel);
	// the first completion ends the round trip only once per request
	assign rtt_stop = i_first_cpl & ~rtt_seen_q;

	pse_req_timer u_full_timer (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset | i_counter_clear),
		.i_start(my_req),
		.i_stop(i_last_cpl),
		.o_busy(full_busy),
		.o_tick(full_tick),
		.o_done(full_done),
		.o_elapsed(full_elapsed)
	);

	pse_req_timer u_rtt_timer (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset | i_counter_clear),
		// rtt idles after the first completion; full busy still blocks
		.i_start(my_req & ~full_busy),
		.i_stop(rtt_stop),
		.o_busy(rtt_busy),
		.o_tick(rtt_tick),
		.o_done(rtt_done),
		.o_elapsed(rtt_elapsed)
	);

	pse_thr_unit u_full_thr (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_clear(my_req & ~full_busy),
		.i_tick(full_tick),
		.i_threshold(i_latency_threshold_setting),
		.o_above(full_above)
	);

	pse_thr_unit u_rtt_thr (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_clear(my_req & ~full_busy),
		.i_tick(rtt_tick),
		.i_threshold(i_latency_threshold_setting),
		.o_above(rtt_above)
	);

	always @(posedge i_clk_sys) begin
		if (i_reset)
			rtt_seen_q <= 1'b0;
		else if (my_req & ~full_busy)
			rtt_seen_q <= 1'b0;
		else if (full_busy & i_first_cpl)
			rtt_seen_q <= 1'b1;
	end

	always @* begin
		count_d = count_q;
		time_d = time_q;
		case (sel_q)
			`PSE_EV_AVG_TIME, `PSE_EV_AVG_CNT: begin
				if (full_done)
					time_d = time_q + full_elapsed + 32'h00000001;
				if (my_req & ~full_busy)
					count_d = count_q + 32'h00000001;
			end
			`PSE_EV_RTT_TIME, `PSE_EV_RTT_CNT: begin
				if (rtt_done)
					time_d = time_q + rtt_elapsed + 32'h00000001;
				if (my_req & ~full_busy)
					count_d = count_q + 32'h00000001;
			end
			`PSE_EV_TIMEOUT:
				count_d = count_q + flag(i_req_timeout);
			`PSE_EV_THR_TIME, `PSE_EV_THR_CNT: begin
				if (full_done) begin
					time_d = full_elapsed + 32'h00000001;
					if (full_above)
						count_d = count_q + 32'h00000001;
				end
			end
			`PSE_EV_RTHR_TIME, `PSE_EV_RTHR_CNT: begin
				if (rtt_done) begin
					time_d = rtt_elapsed + 32'h00000001;
					if (rtt_above)
						count_d = count_q + 32'h00000001;
				end
			end
			`PSE_EV_TX_DW:
				count_d = count_q + widen(i_tx_dwords);
			`PSE_EV_RX_DW:
				count_d = count_q + widen(i_rx_dwords);
			`PSE_EV_TX_DLLP:
				count_d = count_q + flag(i_tx_dllp);
			`PSE_EV_TX_FC:
				count_d = count_q + flag(i_tx_fc_dllp);
			`PSE_EV_TX_ACK:
				count_d = count_q + flag(i_tx_ack_dllp);
			`PSE_EV_RX_DLLP:
				count_d = count_q + flag(i_rx_dllp);
			`PSE_EV_RX_FC:
				count_d = count_q + flag(i_rx_fc_dllp);
			`PSE_EV_RX_ACK:
				count_d = count_q + flag(i_rx_ack_dllp);
			`PSE_EV_RX_NAK:
				count_d = count_q + flag(i_rx_nak_dllp);
			default: begin
				count_d = count_q;
				time_d = time_q;
			end
		endcase
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			count_q <= `PSE_ZERO_CNT;
			time_q <= `PSE_ZERO_CNT;
			sel_q <= 8'h00;
		end else if (i_counter_clear | (i_event_sel != sel_q)) begin
			// a new selection starts from zero; a request already in flight keeps its timer and still adds its whole time
			count_q <= `PSE_ZERO_CNT;
			time_q <= `PSE_ZERO_CNT;
			sel_q <= i_event_sel;
		end else begin
			count_q <= count_d;
			time_q <= time_d;
		end
	end
endmodule

/* File: rtl/pse_defs.vh */
// constants for the statistics event sources
`ifndef PSE_DEFS_VH
`define PSE_DEFS_VH
`define PSE_CODE_W 8
`define PSE_CNT_W 32
`define PSE_THR_W 16
`define PSE_CLIENT_W 4
`define PSE_EV_AVG_TIME 8'h40
`define PSE_EV_AVG_CNT 8'h41
`define PSE_EV_RTT_TIME 8'h42
`define PSE_EV_RTT_CNT 8'h43
`define PSE_EV_TIMEOUT 8'h44
`define PSE_EV_THR_TIME 8'h45
`define PSE_EV_THR_CNT 8'h46
`define PSE_EV_RTHR_TIME 8'h47
`define PSE_EV_RTHR_CNT 8'h48
`define PSE_EV_TX_DW 8'h50
`define PSE_EV_RX_DW 8'h51
`define PSE_EV_TX_DLLP 8'h52
`define PSE_EV_TX_FC 8'h53
`define PSE_EV_TX_ACK 8'h54
`define PSE_EV_RX_DLLP 8'h55
`define PSE_EV_RX_FC 8'h56
`define PSE_EV_RX_ACK 8'h57
`define PSE_EV_RX_NAK 8'h58
`define PSE_UNIT_NS 96
`define PSE_CLK_NS 10
`define PSE_UNIT_CYC ((`PSE_UNIT_NS + `PSE_CLK_NS - 1) / `PSE_CLK_NS)
`define PSE_UNIT_CW 4
`define PSE_ZERO_CNT 32'h00000000
`endif

/* File: rtl/pse_req_timer.v */
// times one outstanding request of the chosen client
`timescale 1ns/10ps
`include "pse_defs.vh"
module pse_req_timer (
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_start,
	input wire i_stop,
	output wire o_busy,
	output wire o_tick,
	output wire o_done,
	output reg [`PSE_CNT_W-1:0] o_elapsed
);
	reg busy_q;
	assign o_busy = busy_q;
	assign o_tick = busy_q;
	assign o_done = busy_q & i_stop;
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			busy_q <= 1'b0;
			o_elapsed <= `PSE_ZERO_CNT;
		end else if (i_start & ~busy_q) begin
			busy_q <= 1'b1;
			o_elapsed <= `PSE_ZERO_CNT;
		end else if (busy_q) begin
			// elapsed holds the final time after stop
			o_elapsed <= o_elapsed + 32'h00000001;
			if (i_stop)
				busy_q <= 1'b0;
		end
	end
endmodule

/* File: rtl/pse_thr_unit.v */
// compares a finished request time with the threshold in 10-cycle units (96 ns rounded up to whole 10 ns cycles)
`timescale 1ns/10ps
`include "pse_defs.vh"
module pse_thr_unit (
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_clear,
	input wire i_tick,
	input wire [`PSE_THR_W-1:0] i_threshold,
	output wire o_above
);
	reg [`PSE_UNIT_CW-1:0] sub_q;
	reg [`PSE_THR_W:0] units_q;
	// one extra bit so long requests saturate past any threshold
	assign o_above = units_q > {1'b0, i_threshold};
	always @(posedge i_clk_sys) begin
		if (i_reset | i_clear) begin
			sub_q <= 4'h0;
			units_q <= 17'h00000;
		end else if (i_tick) begin
			if (sub_q == `PSE_UNIT_CYC - 1) begin
				sub_q <= 4'h0;
				if (~units_q[`PSE_THR_W])
					units_q <= units_q + 17'h00001;
			end else begin
				sub_q <= sub_q + 4'h1;
			end
		end
	end
endmodule

/* File: bench/pse_props.sv */
// concurrent checks on the event counter ports
`timescale 1ns/10ps
module pse_props (
	input i_clk_sys,
	input i_reset,
	input [7:0] i_event_sel,
	input [3:0] i_client_sel,
	input i_counter_clear,
	input i_rd_req,
	input [3:0] i_rd_req_client,
	input i_req_timeout,
	input [1:0] i_tx_dwords,
	input [1:0] i_rx_dwords,
	input i_tx_dllp,
	input i_tx_fc_dllp,
	input i_tx_ack_dllp,
	input i_rx_dllp,
	input i_rx_fc_dllp,
	input i_rx_ack_dllp,
	input i_rx_nak_dllp,
	input [31:0] o_count,
	input [31:0] o_time_acc,
	input o_full_busy,
	input o_rtt_busy
);
	wire [6:0] fl = {i_rx_nak_dllp, i_rx_ack_dllp, i_rx_fc_dllp, i_rx_dllp, i_tx_ack_dllp,
		i_tx_fc_dllp, i_tx_dllp};
	reg [7:0] s_q;
	reg nr_q, ok_q, fg_q, mr_q;
	reg [31:0] p_q, fc_q, rc_q;
	// ok_q: code settled a cycle ago, so that edge really counted
	always @(posedge i_clk_sys) begin
		s_q <= i_event_sel;
		nr_q <= !i_reset;
		ok_q <= nr_q && !i_reset && !i_counter_clear && i_event_sel == s_q;
		fg_q <= fl[i_event_sel[2:0] - 3'h2];
		mr_q <= i_rd_req && i_rd_req_client == i_client_sel && !o_full_busy;
		p_q <= o_count;
		fc_q <= o_full_busy ? fc_q + 32'h1 : 32'h0;
		rc_q <= o_rtt_busy ? rc_q + 32'h1 : 32'h0;
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence full_end; $fell(o_full_busy); endsequence
	sequence rtt_end; $fell(o_rtt_busy); endsequence
	tx_dw_a: assert property (ok_q && s_q == 8'h50 |->
		o_count == p_q + $past(i_tx_dwords)) else $error("tx dwords");
	rx_dw_a: assert property (ok_q && s_q == 8'h51 |->
		o_count == p_q + $past(i_rx_dwords)) else $error("rx dwords");
	dllp_a: assert property (ok_q && s_q > 8'h51 && s_q < 8'h59 |->
		o_count == p_q + fg_q) else $error("dllp count");
	tmo_a: assert property (ok_q && s_q == 8'h44 |->
		o_count == p_q + $past(i_req_timeout)) else $error("timeouts");
	other_a: assert property (ok_q && !(s_q inside {[8'h40:8'h48], [8'h50:8'h58]}) |->
		o_count == 32'h0 && o_time_acc == 32'h0) else $error("stray count");
	req_a: assert property (ok_q && s_q == 8'h40 && mr_q |->
		o_count == p_q + 32'h1 && o_full_busy) else $error("request count");
	full_t_a: assert property (ok_q && s_q == 8'h40 ##0 full_end |->
		o_time_acc == $past(o_time_acc) + fc_q) else $error("full time");
	rtt_t_a: assert property (ok_q && s_q == 8'h42 ##0 rtt_end |->
		o_time_acc == $past(o_time_acc) + rc_q) else $error("rtt time");
endmodule
bind pse_stat_events pse_props u_props (.*);

/* File: bench/pse_host_model.sv */
// far side: read requests and their completions
`timescale 1ns/10ps
module pse_host_model (
	input i_clk_sys,
	output reg o_rd_req = 1'h0,
	output reg [3:0] o_client = 4'h0,
	output reg o_first_cpl = 1'h0,
	output reg o_last_cpl = 1'h0
);
	// one request in flight; first then last completion
	task issue(input [3:0] c, input [7:0] d1, input [7:0] d2);
		begin
			o_rd_req = 1'h1;
			o_client = c;
			@(negedge i_clk_sys);
			o_rd_req = 1'h0;
			o_client = ~c;
			repeat (d1 - 1) @(negedge i_clk_sys);
			o_first_cpl = 1'h1;
			@(negedge i_clk_sys);
			o_first_cpl = 1'h0;
			repeat (d2 - 1) @(negedge i_clk_sys);
			o_last_cpl = 1'h1;
			@(negedge i_clk_sys);
			o_last_cpl = 1'h0;
		end
	endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the event counters
`timescale 1ns/10ps
module tb_top;
	reg i_clk_sys = 1'h0, i_reset = 1'h1, i_counter_clear = 1'h0, i_req_timeout = 1'h0;
	reg [7:0] i_event_sel = 8'h0;
	reg [3:0] i_client_sel = 4'h5;
	reg [15:0] i_latency_threshold_setting = 16'h1;
	reg [1:0] i_tx_dwords = 2'h0, i_rx_dwords = 2'h0;
	reg [6:0] fl = 7'h0;
	wire i_rd_req, i_first_cpl, i_last_cpl, o_full_busy, o_rtt_busy;
	wire [3:0] i_rd_req_client;
	wire [31:0] o_count, o_time_acc;
	int fail_count = 0, checked = 0, seed = 32'h6834, cyc = 0, j, k, a, b, ec, et;
	pse_stat_events dut (.*, .i_tx_dllp(fl[0]), .i_tx_fc_dllp(fl[1]), .i_tx_ack_dllp(fl[2]),
		.i_rx_dllp(fl[3]), .i_rx_fc_dllp(fl[4]), .i_rx_ack_dllp(fl[5]), .i_rx_nak_dllp(fl[6]));
	pse_host_model hm (.i_clk_sys(i_clk_sys), .o_rd_req(i_rd_req), .o_client(i_rd_req_client),
		.o_first_cpl(i_first_cpl), .o_last_cpl(i_last_cpl));
	function int inc(input [7:0] c);
		inc = c == 8'h44 ? i_req_timeout : c == 8'h50 ? i_tx_dwords : c == 8'h51 ? i_rx_dwords
			: c > 8'h51 && c < 8'h59 ? fl[c[2:0] - 3'h2] : 0;
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %0h want %0h", $time, g, e);
		end
	endtask
	// a code change clears, so expectations restart at zero
	task pick(input [7:0] c);
		i_event_sel = c;
		ec = 0;
		et = 0;
		repeat (2) @(negedge i_clk_sys);
	endtask
	task traffic(input [7:0] c);
		pick(c);
		for (k = 0; k < 20; k++) begin
			{i_req_timeout, fl} = $random(seed);
			i_tx_dwords = k ? {$random(seed)} % 3 : 2'h2;
			i_rx_dwords = k ? {$random(seed)} % 3 : 2'h2;
			ec += inc(c);
			@(negedge i_clk_sys);
		end
		{i_req_timeout, fl, i_tx_dwords, i_rx_dwords} = 12'h0;
		chk(o_count, ec);
		i_counter_clear = 1'h1;
		@(negedge i_clk_sys);
		i_counter_clear = 1'h0;
		chk(o_count, 32'h0);
	endtask
	task test_done;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial forever #5 i_clk_sys = ~i_clk_sys;
	// whole run needs well under a thousand cycles
	always @(posedge i_clk_sys) begin
		if (++cyc == 4000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (8) @(negedge i_clk_sys);
		i_reset = 1'h0;
		for (j = 8'h50; j < 8'h59; j++) traffic(j);
		traffic(8'h44);
		traffic(8'h49);
		for (j = 0; j < 4; j++) begin
			pick(8'h40 + 2 * (j % 2) + j / 2);
			for (k = 0; k < 6; k++) begin
				a = 1 + {$random(seed)} % 6;
				b = 1 + {$random(seed)} % 6;
				hm.issue(k == 2 ? 4'h3 : 4'h5, a, b);
				ec += k != 2;
				et += k == 2 ? 0 : j % 2 ? a : a + b;
			end
			chk(o_count, ec);
			chk(o_time_acc, et);
			pick(8'h46 + 2 * (j % 2) - j / 2);
			hm.issue(4'h5, 8'h1E, 8'h5);
			hm.issue(4'h5, 8'h3, 8'h5);
			chk(o_count, 32'h1);
			chk(o_time_acc, j % 2 ? 32'h3 : 32'h8);
		end
		test_done;
	end
endmodule
